// ===== hw/mior_read_path.sv
// Read-command front end of a serial NOR flash: opcode decode, address,
// mode byte, dummy clocks and data shift-out on one, two or four lines.
// Assumes the array answers memValid/memData for memAddr while memReady.
// The serial clock is sampled by sys_clk, so it must stay well below half
// the system clock rate.
`timescale 1ns/1ps
`include "mior_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Data FIFO between array fetch and output shifter
module mior_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic flush,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } mior_fifo_t;
   mior_fifo_t st, next_st;
   logic push, pop;

   // Handshakes straight from the fill level
   assign inReady = (st.count != (AW+1)'(DEPTH));
   assign outValid = (st.count != '0);
   assign outData = st.mem[st.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = st.wrPtr + AW'(1);
      end
      if (pop)
         next_st.rdPtr = st.rdPtr + AW'(1);
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
      // Flush drops everything, stale prefetch must never leak out
      if (flush)
      begin
         next_st.wrPtr = '0;
         next_st.rdPtr = '0;
         next_st.count = '0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end
endmodule

////////////////////////////////////////////////////////////////////////////
// How it works
// (R01) Fast read: opcode, 3-byte address, dummy byte, data.
// (R02) Sample on rising edge, shift out on falling.
// (R03) Address increments per byte, wraps to zero.
// (R04) Reads ignored while internal write cycle busy.
// (R05) Chip select high ends read, stops driving.
// (R06) Four-line mode fast read dummies follow parameter.
// (R07) Double-edge fast read: six dummies, lines undriven.
// (R08) Dual output: single-line address, two-line data.
// (R09) Dual I/O: address, dummy, data on two lines.
// (R10) Dummy select bit: four or eight dummies.
// (R11) Mode key 10 skips next opcode.
// (R12) Other key or reset command leaves continuous mode.
// (R13) Host sends non-10 key unless continuing.
// (R14) Double-edge dual I/O: address two bits per edge.
// (R15) Double-edge dual I/O continuous mode likewise.
// (R16) Host sends all-ones on line 0 to exit.
// (R17) Quad output: single-line address, four-line data.
// (R18) Most significant bit first, top line highest.
module mior_read_path #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOeN,
   input wire logic busy,
   input wire logic quadCmdMode,
   input wire logic [1:0] readParam,
   input wire logic dummyCountSelect,
   input wire logic contModeReset,
   output logic contModeActive,
   output logic [23:0] memAddr,
   output logic memReady,
   input wire logic memValid,
   input wire logic [7:0] memData
);
   typedef struct packed {
      logic sclkS1, sclkS2, sclkS3;
      logic csS1, csS2, csS3;
      logic [3:0] ioS1, ioS2;
      mior_pkg::mior_phase_t phase;
      mior_pkg::mior_cmd_t cmd;
      logic dtr;
      logic [2:0] lanes;
      logic [23:0] shiftIn;
      logic [4:0] bitCnt;
      logic [3:0] dummyCnt, dummyTgt;
      logic contMode, contDtr, fetchOn, flush, firstOut;
      logic [23:0] addr;
      logic [7:0] outByte;
      logic [3:0] bitsLeft;
      logic [3:0] ioOut, ioOeN;
   } mior_state_t;
   mior_state_t st, next_st;
   logic rise, fall, csFall, inEv, outEv, fifoInReady, fifoValid, pop;
   logic [7:0] fifoData;

   // Lines used by the address phase
   function automatic logic [2:0] mior_addr_lanes(mior_pkg::mior_cmd_t c,
                                                  logic qpi);
      if (qpi)
         return 3'h4;
      if (c == mior_pkg::dual_io_read ||
          c == mior_pkg::double_edge_dual_io_read)
         return 3'h2;
      return 3'h1;
   endfunction

   // Lines used by the data phase
   function automatic logic [2:0] mior_data_lanes(mior_pkg::mior_cmd_t c,
                                                  logic qpi);
      if (qpi || c == mior_pkg::quad_output_read)
         return 3'h4;
      if (c == mior_pkg::single_fast_read ||
          c == mior_pkg::double_edge_fast_read)
         return 3'h1;
      return 3'h2;
   endfunction

   // Edges are seen on the second synchroniser stage only
   assign rise = st.sclkS2 && !st.sclkS3;
   assign fall = !st.sclkS2 && st.sclkS3;
   assign csFall = !st.csS2 && st.csS3;
   // A double-rate phase opens on a rising edge; the falling edge that
   // closes the opcode clock must not be taken as an address bit
   assign inEv = st.dtr ? (rise || (fall && st.bitCnt != 5'h0)) : rise; // (R07)
   assign outEv = (st.firstOut || !st.dtr) ? fall : (rise || fall);
   assign pop = (st.phase == mior_pkg::PH_DATA) && outEv &&
                (st.bitsLeft == 4'h0) && fifoValid;
   assign memReady = st.fetchOn && !st.flush && fifoInReady;
   assign memAddr = st.addr;
   assign ioOut = st.ioOut;
   assign ioOeN = st.ioOeN;
   assign contModeActive = st.contMode;

   mior_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_mior_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .flush(st.flush),
      .inValid(memValid && memReady),
      .inData(memData),
      .inReady(fifoInReady),
      .outValid(fifoValid),
      .outData(fifoData),
      .outReady(pop)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic [23:0] sh;
      logic [4:0] cnt;
      logic [7:0] b;
      sh = st.shiftIn;
      cnt = st.bitCnt + {2'h0, st.lanes};
      b = st.outByte;
      next_st = st;
      next_st.sclkS1 = sclk;
      next_st.sclkS2 = st.sclkS1;
      next_st.sclkS3 = st.sclkS2;
      next_st.csS1 = csN;
      next_st.csS2 = st.csS1;
      next_st.csS3 = st.csS2;
      next_st.ioS1 = ioIn;
      next_st.ioS2 = st.ioS1;
      next_st.flush = 1'b0;
      // Top line holds the most significant bit of each group
      unique case (st.lanes)
         3'h1: sh = {st.shiftIn[22:0], st.ioS2[0]}; // (R18)
         3'h2: sh = {st.shiftIn[21:0], st.ioS2[1:0]}; // (R18)
         default: sh = {st.shiftIn[19:0], st.ioS2}; // (R18)
      endcase
      // Each accepted array byte moves the read address on
      if (memValid && memReady)
         next_st.addr = st.addr + 24'h1; // (R03)
      unique case (st.phase)
         mior_pkg::PH_IDLE, mior_pkg::PH_IGNORE: ;
         mior_pkg::PH_OPCODE:
            if (rise)
            begin
               next_st.shiftIn = sh;
               next_st.bitCnt = cnt;
               if (cnt == `MIOR_OP_BITS)
               begin
                  next_st.bitCnt = 5'h0;
                  next_st.phase = mior_pkg::PH_ADDR;
                  next_st.dtr = 1'b0;
                  unique case (sh[7:0])
                     `MIOR_OP_SFAST: next_st.cmd = mior_pkg::single_fast_read;
                     `MIOR_OP_DFAST:
                     begin
                        next_st.cmd = mior_pkg::double_edge_fast_read;
                        next_st.dtr = 1'b1; // (R07)
                     end
                     `MIOR_OP_DOUT: next_st.cmd = mior_pkg::dual_output_read;
                     `MIOR_OP_DIO: next_st.cmd = mior_pkg::dual_io_read;
                     `MIOR_OP_DDIO:
                     begin
                        next_st.cmd = mior_pkg::double_edge_dual_io_read;
                        next_st.dtr = 1'b1; // (R14)
                     end
                     `MIOR_OP_QOUT: next_st.cmd = mior_pkg::quad_output_read;
                     default: next_st.phase = mior_pkg::PH_IGNORE;
                  endcase
                  // Four-line command mode carries only the fast read
                  if (quadCmdMode && sh[7:0] != `MIOR_OP_SFAST)
                     next_st.phase = mior_pkg::PH_IGNORE;
                  // A running write cycle is left alone
                  if (busy)
                     next_st.phase = mior_pkg::PH_IGNORE; // (R04)
                  next_st.lanes = mior_addr_lanes(next_st.cmd, quadCmdMode);
               end
            end
         mior_pkg::PH_ADDR:
            if (inEv)
            begin
               next_st.shiftIn = sh;
               next_st.bitCnt = cnt;
               if (cnt == `MIOR_ADDR_BITS)
               begin
                  // Start prefetch now, dummies hide the array latency
                  next_st.bitCnt = 5'h0;
                  next_st.addr = sh;
                  next_st.flush = 1'b1;
                  next_st.fetchOn = 1'b1;
                  next_st.dummyCnt = 4'h0;
                  next_st.phase = mior_pkg::PH_DUMMY;
                  unique case (st.cmd)
                     mior_pkg::single_fast_read:
                        next_st.dummyTgt = quadCmdMode ?
                           4'(`MIOR_QPI_DUMMY >> {readParam, 2'h0}) : // (R06)
                           `MIOR_DUMMY_STD; // (R01)
                     mior_pkg::double_edge_fast_read:
                        next_st.dummyTgt = `MIOR_DUMMY_DFAST; // (R07)
                     mior_pkg::dual_io_read,
                     mior_pkg::double_edge_dual_io_read:
                        next_st.phase = mior_pkg::PH_MODE; // (R09)
                     default: next_st.dummyTgt = `MIOR_DUMMY_STD; // (R08)
                  endcase
               end
            end
         mior_pkg::PH_MODE:
            if (inEv)
            begin
               next_st.shiftIn = sh;
               next_st.bitCnt = cnt;
               if (cnt == `MIOR_MODE_BITS)
               begin
                  // Key 10 arms opcode skipping, anything else disarms
                  next_st.contMode = (sh[5:4] == `MIOR_CONT_KEY); // (R11)
                  next_st.contDtr = st.dtr; // (R15)
                  next_st.bitCnt = 5'h0;
                  next_st.phase = mior_pkg::PH_DUMMY;
                  if (st.dtr)
                     next_st.dummyTgt = `MIOR_DUMMY_DDIO;
                  else
                     next_st.dummyTgt = dummyCountSelect ?
                        `MIOR_DUMMY_DIO_HI : `MIOR_DUMMY_DIO_LO; // (R10)
               end
            end
         mior_pkg::PH_DUMMY:
            // Dummies count whole clocks, lines stay undriven
            if (rise)
            begin
               next_st.dummyCnt = st.dummyCnt + 4'h1;
               if (st.dummyCnt + 4'h1 == st.dummyTgt)
               begin
                  next_st.phase = mior_pkg::PH_DATA;
                  next_st.firstOut = 1'b1;
                  next_st.bitsLeft = 4'h0;
                  next_st.lanes = mior_data_lanes(st.cmd, quadCmdMode);
               end
            end
         mior_pkg::PH_DATA:
            // Change outputs on falling edges, both edges when double
            if (outEv)
            begin
               if (st.bitsLeft == 4'h0)
                  b = fifoValid ? fifoData : 8'h00;
               next_st.firstOut = 1'b0;
               unique case (st.lanes)
                  3'h1:
                  begin
                     next_st.ioOut = {2'h0, b[7], 1'b0}; // (R02)
                     next_st.ioOeN = `MIOR_OEN_X1; // (R01)
                  end
                  3'h2:
                  begin
                     next_st.ioOut = {2'h0, b[7:6]}; // (R18)
                     next_st.ioOeN = `MIOR_OEN_X2; // (R08)
                  end
                  default:
                  begin
                     next_st.ioOut = b[7:4]; // (R18)
                     next_st.ioOeN = `MIOR_OEN_X4; // (R17)
                  end
               endcase
               next_st.outByte = b << st.lanes;
               next_st.bitsLeft = (st.bitsLeft == 4'h0 ? 4'h8 : st.bitsLeft)
                                  - {1'b0, st.lanes};
            end
         default: next_st.phase = mior_pkg::PH_IDLE;
      endcase
      // Start of frame: continuous mode goes straight to the address
      if (csFall)
      begin
         next_st.bitCnt = 5'h0;
         next_st.shiftIn = 24'h0;
         next_st.lanes = quadCmdMode ? 3'h4 : 3'h1;
         next_st.phase = mior_pkg::PH_OPCODE;
         if (st.contMode)
         begin
            next_st.cmd = st.contDtr ? mior_pkg::double_edge_dual_io_read :
                          mior_pkg::dual_io_read; // (R11)
            next_st.dtr = st.contDtr; // (R15)
            next_st.lanes = 3'h2;
            next_st.phase = busy ? mior_pkg::PH_IGNORE :
                            mior_pkg::PH_ADDR; // (R04)
         end
      end
      // Frame end releases the lines and stops fetching
      if (st.csS2)
      begin
         next_st.phase = mior_pkg::PH_IDLE; // (R05)
         next_st.ioOeN = `MIOR_OEN_OFF; // (R05)
         next_st.fetchOn = 1'b0;
         next_st.flush = st.fetchOn;
      end
      if (contModeReset)
         next_st.contMode = 1'b0; // (R12)
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         st <= '0;
         st.sclkS1 <= 1'b0;
         st.csS1 <= 1'b1;
         st.csS2 <= 1'b1;
         st.csS3 <= 1'b1;
         st.ioOeN <= `MIOR_OEN_OFF;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_csRise;
      st.csS2 && !st.csS3;
   endsequence
   sequence s_contEntry;
      csFall && st.contMode && !busy && !st.csS2;
   endsequence
   sequence s_modeDone;
      st.phase == mior_pkg::PH_MODE && inEv && st.bitCnt ==
         `MIOR_MODE_BITS - {2'h0, st.lanes} && !st.csS2 && !contModeReset;
   endsequence

   a_cs_stop: assert property (s_csRise |=> // (R05)
      st.phase == mior_pkg::PH_IDLE && ioOeN == `MIOR_OEN_OFF ##1
      !memReady)
      else $error("frame end did not release lines");
   a_busy_ignore: assert property ( // (R04)
      st.phase == mior_pkg::PH_IGNORE |-> ioOeN == `MIOR_OEN_OFF && !pop)
      else $error("ignored read drove lines");
   a_fall_shift: assert property ( // (R02)
      $changed(ioOut) && !st.dtr && !$past(st.csS2) |-> $past(fall))
      else $error("single-rate output changed off a falling edge");
   a_addr_step: assert property ( // (R03)
      memValid && memReady && st.phase == mior_pkg::PH_DATA |=>
      memAddr == $past(memAddr) + 24'h1)
      else $error("read address did not step by one");
   a_cont_skip: assert property (s_contEntry |=> // (R11)
      st.phase == mior_pkg::PH_ADDR && st.lanes == 3'h2)
      else $error("continuous frame did not start at address");
   a_cont_exit: assert property ( // (R12)
      s_modeDone ##0 (st.shiftIn[3:2] != `MIOR_CONT_KEY) |=> !st.contMode)
      else $error("continuous mode kept with wrong key");
   a_dio_dummy: assert property ( // (R10)
      st.phase == mior_pkg::PH_DUMMY && st.cmd == mior_pkg::dual_io_read &&
      $stable(dummyCountSelect) |-> st.dummyTgt ==
      (dummyCountSelect ? `MIOR_DUMMY_DIO_HI : `MIOR_DUMMY_DIO_LO))
      else $error("dual I/O dummy count wrong");
   a_dtr_quiet: assert property ( // (R07)
      st.phase == mior_pkg::PH_DUMMY &&
      st.cmd == mior_pkg::double_edge_fast_read |->
      ioOeN == `MIOR_OEN_OFF && st.dummyTgt == `MIOR_DUMMY_DFAST)
      else $error("double-edge fast read dummy phase wrong");
   a_data_lines: assert property ( // (R09)
      st.phase == mior_pkg::PH_DATA && !st.firstOut && !st.csS2 |->
      ioOeN == (st.lanes == 3'h4 ? `MIOR_OEN_X4 :
      st.lanes == 3'h2 ? `MIOR_OEN_X2 : `MIOR_OEN_X1))
      else $error("data driven on wrong lines");
endmodule

// ===== hw/mior_cfg.svh
// Constants of the multi-line flash read path: opcodes, phase lengths,
// dummy clock counts and pin reset values.
// Assumes inclusion by bare name from the design files.
`ifndef MIOR_CFG_SVH
`define MIOR_CFG_SVH
`define MIOR_OP_SFAST 8'h0b
`define MIOR_OP_DFAST 8'h0d
`define MIOR_OP_DOUT 8'h3b
`define MIOR_OP_DIO 8'hbb
`define MIOR_OP_DDIO 8'hbd
`define MIOR_OP_QOUT 8'h6b
`define MIOR_OP_BITS 5'h08
`define MIOR_ADDR_BITS 5'h18
`define MIOR_MODE_BITS 5'h08
`define MIOR_CONT_KEY 2'h2
`define MIOR_DUMMY_STD 4'h8
`define MIOR_DUMMY_DFAST 4'h6
`define MIOR_DUMMY_DIO_LO 4'h4
`define MIOR_DUMMY_DIO_HI 4'h8
`define MIOR_DUMMY_DDIO 4'h4
// Four-line command mode dummies, one nibble per parameter value
`define MIOR_QPI_DUMMY 16'ha864
`define MIOR_OEN_OFF 4'hf
`define MIOR_OEN_X1 4'hd
`define MIOR_OEN_X2 4'hc
`define MIOR_OEN_X4 4'h0
`endif

// ===== hw/mior_pkg.sv
// Types of the multi-line flash read path: phases and read commands.
// Assumes nothing of its surroundings.
package mior_pkg;
   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_OPCODE = 3'h1,
      PH_ADDR = 3'h2,
      PH_MODE = 3'h3,
      PH_DUMMY = 3'h4,
      PH_DATA = 3'h5,
      PH_IGNORE = 3'h6
   } mior_phase_t;
   typedef enum logic [2:0] {
      single_fast_read = 3'h0,
      double_edge_fast_read = 3'h1,
      dual_output_read = 3'h2,
      dual_io_read = 3'h3,
      double_edge_dual_io_read = 3'h4,
      quad_output_read = 3'h5
   } mior_cmd_t;
endpackage

// ===== testbench/mior_host_model.sv
// Host flash controller model: serial clock, chip select, io lines.
// Assumes sys_clk at 100 MHz; the serial clock averages 125 ns a period.
`timescale 1ns/1ps
module mior_host_model (
   input wire logic sys_clk,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOeN,
   output logic sclk,
   output logic csN,
   output logic [3:0] ioIn
);
   logic [3:0] hostEn = 4'h0;
   logic [3:0] hostVal = 4'h0;
   logic tog = 1'b0;
   logic [7:0] sh;
   int nb;
   realtime tNext;
   logic [7:0] got[$];
   logic [3:0] oenSeen;

   initial
   begin
      sclk = 1'b0;
      csN = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Released lines toggle, so a stale value never passes for data
   always @(posedge sys_clk)
      tog <= ~tog;
   assign ioIn = (hostEn & hostVal) | (~hostEn & ~ioOeN & ioOut)
      | (~hostEn & ioOeN & {4{tog}});

   // Quarter period wait, kept on sys_clk edges, averaging 31.25 ns
   task automatic waitQ();
      tNext += 31.25;
      while ($realtime < tNext)
         @(posedge sys_clk);
   endtask

   // Lines read as the host sees them; a released line yields no data
   task automatic grab(input int w);
      if (nb == 0)
         oenSeen = ioOeN;
      if (ioOeN[(w == 1) ? 1 : 0] !== 1'b0)
         return;
      for (int b = w - 1; b >= 0; b--)
      begin
         sh = {sh[6:0], (w == 1) ? ioIn[1] : ioIn[b]};
         nb++;
         if (nb % 8 == 0)
            got.push_back(sh);
      end
   endtask

   // One serial clock; data changes mid-phase, never on an edge
   task automatic tick(input int w, input bit ddr, input logic [3:0] g0,
      input logic [3:0] g1, input int dw);
      hostEn <= 4'((1 << w) - 1);
      hostVal <= g0;
      waitQ();
      if (dw > 0)
         grab(dw);
      sclk <= 1'b1;
      waitQ();
      hostVal <= g1;
      waitQ();
      if (dw > 0 && ddr)
         grab(dw);
      sclk <= 1'b0;
      waitQ();
   endtask

   task automatic sendv(input logic [23:0] v, input int n, input int w,
      input bit ddr);
      logic [23:0] m;
      m = 24'((1 << w) - 1);
      for (int i = n / w - 1; i >= 0; i -= ddr ? 2 : 1)
         tick(w, ddr, 4'((v >> (i * w)) & m),
            4'((v >> ((ddr ? i - 1 : i) * w)) & m), 0);
   endtask

   // Whole frame; opW of zero skips the opcode for continuous reads
   task automatic frame(input logic [7:0] op, input int opW,
      input logic [23:0] a, input int aW, input bit ddr,
      input logic [7:0] md, input int mW, input int dum, input int dW,
      input int nu);
      got.delete();
      nb = 0;
      oenSeen = 4'hx;
      @(posedge sys_clk);
      tNext = $realtime;
      csN <= 1'b0;
      waitQ();
      if (opW > 0)
         sendv({16'h0, op}, 8, opW, 1'b0);
      sendv(a, 24, aW, ddr);
      if (mW > 0)
         sendv({16'h0, md}, 8, mW, ddr);
      repeat (dum)
         tick(0, 1'b0, 4'h0, 4'h0, 0);
      repeat (ddr ? nu / 2 : nu)
         tick(0, ddr, 4'h0, 4'h0, dW);
      csN <= 1'b1;
      waitQ();
   endtask
endmodule

// ===== testbench/tb.sv
// Top bench: host model on the serial side, pattern array on fetch side.
// Assumes the default FIFO depth of 16 and plain control ports.
`timescale 1ns/1ps
module tb;
   typedef struct {
      logic [7:0] op;
      int opW, aW;
      bit ddr;
      int mW;
      logic [7:0] md;
      int dum, dW;
      logic [23:0] a;
      int nb;
      bit dc, qm;
      logic [1:0] rp;
      logic [3:0] oen;
   } mior_row_t;

   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic sclk;
   logic csN;
   logic [3:0] ioIn;
   logic [3:0] ioOut;
   logic [3:0] ioOeN;
   logic busy = 1'b0;
   logic quadCmdMode = 1'b0;
   logic [1:0] readParam = 2'h0;
   logic dummyCountSelect = 1'b0;
   logic contModeReset = 1'b0;
   logic contModeActive;
   logic [23:0] memAddr;
   logic memReady;
   logic memValid = 1'b1;
   logic [7:0] memData;
   logic slow = 1'b0;
   logic sawFull = 1'b0;
   int errCount = 0;
   int nTests = 0;
   int cyc = 0;
   // Ordinary reads: each command and line count, with extra rows for dummy select, address wrap and read parameter
   mior_row_t rows[10] = '{
      '{8'h0b, 1, 1, 0, 0, 8'h00, 8, 1, 24'h000123, 3, 0, 0, 2'h0, 4'hd},
      '{8'h0d, 1, 1, 1, 0, 8'h00, 6, 1, 24'h00abcd, 2, 0, 0, 2'h0, 4'hd},
      '{8'h3b, 1, 1, 0, 0, 8'h00, 8, 2, 24'h012340, 3, 0, 0, 2'h0, 4'hc},
      '{8'hbb, 1, 2, 0, 2, 8'h00, 4, 2, 24'h0a5a5a, 3, 0, 0, 2'h0, 4'hc},
      '{8'hbb, 1, 2, 0, 2, 8'h00, 8, 2, 24'h100001, 2, 1, 0, 2'h0, 4'hc},
      '{8'hbd, 1, 2, 1, 2, 8'h00, 4, 2, 24'h3c3c3c, 3, 0, 0, 2'h0, 4'hc},
      '{8'h6b, 1, 1, 0, 0, 8'h00, 8, 4, 24'h7ffffe, 3, 0, 0, 2'h0, 4'h0},
      '{8'h0b, 1, 1, 0, 0, 8'h00, 8, 1, 24'hfffffe, 3, 0, 0, 2'h0, 4'hd},
      '{8'h0b, 4, 4, 0, 0, 8'h00, 4, 4, 24'h000800, 2, 0, 1, 2'h0, 4'h0},
      '{8'h0b, 4, 4, 0, 0, 8'h00, 10, 4, 24'h001000, 2, 0, 1, 2'h3, 4'h0}
   };

   ////////////////////////////////////////////////////////////////////////
   // Array stand-in: byte depends on every address bit
   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction
   assign memData = pat(memAddr);

   always #5 sys_clk = ~sys_clk;

   // Stall pattern, full-FIFO watch and hang limit
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      memValid <= !slow || cyc % 4 == 0;
      if (ioOeN !== 4'hf && memReady === 1'b0)
         sawFull <= 1'b1;
      if (cyc == 60000)
      begin
         errCount++;
         conclude();
      end
   end

   mior_read_path #(.FIFO_DEPTH(16)) i_mior_read_path (
      .sys_clk(sys_clk), .srst(srst), .sclk(sclk), .csN(csN),
      .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .busy(busy),
      .quadCmdMode(quadCmdMode), .readParam(readParam),
      .dummyCountSelect(dummyCountSelect), .contModeReset(contModeReset),
      .contModeActive(contModeActive), .memAddr(memAddr),
      .memReady(memReady), .memValid(memValid), .memData(memData));

   mior_host_model i_mior_host_model (
      .sys_clk(sys_clk), .ioOut(ioOut), .ioOeN(ioOeN), .sclk(sclk),
      .csN(csN), .ioIn(ioIn));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // A refused read returns no bytes and leaves the lines released
   task automatic run(input mior_row_t r);
      dummyCountSelect <= r.dc;
      quadCmdMode <= r.qm;
      readParam <= r.rp;
      i_mior_host_model.frame(r.op, r.opW, r.a, r.aW, r.ddr, r.md, r.mW,
         r.dum, r.dW, r.nb * 8 / r.dW);
      check(24'(i_mior_host_model.got.size()),
         r.oen == 4'hf ? 0 : r.nb);
      foreach (i_mior_host_model.got[i])
         check(i_mior_host_model.got[i], pat(r.a + 24'(i)));
      check(i_mior_host_model.oenSeen, r.oen);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mior_row_t r;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check(ioOeN, 4'hf);
      check(contModeActive, 1'b0);
      check(memAddr, 24'h0);
      foreach (rows[i])
         run(rows[i]);
      // Busy internal cycle, then the same read once it is over
      r = rows[0];
      r.oen = 4'hf;
      busy <= 1'b1;
      run(r);
      busy <= 1'b0;
      run(rows[0]);
      // Chip select raised in mid-byte
      i_mior_host_model.frame(8'h0b, 1, 24'h40, 1, 0, 8'h0, 0, 8, 1, 4);
      repeat (3) @(posedge sys_clk);
      check(ioOeN, 4'hf);
      // Two-line continuous read: armed, used, then left
      r = rows[3];
      r.md = 8'h20;
      run(r);
      check(contModeActive, 1'b1);
      r.opW = 0;
      r.md = 8'h00;
      r.a = 24'h00f000;
      run(r);
      check(contModeActive, 1'b0);
      // Double-edge variant, left with all-ones on line 0
      r = rows[5];
      r.md = 8'h20;
      run(r);
      check(contModeActive, 1'b1);
      r.opW = 0;
      r.md = 8'hff;
      run(r);
      check(contModeActive, 1'b0);
      // Reset command clears the armed state
      r = rows[3];
      r.md = 8'h20;
      run(r);
      contModeReset <= 1'b1;
      @(posedge sys_clk);
      contModeReset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(contModeActive, 1'b0);
      run(rows[0]);
      // Long read fills the FIFO; then a stalling array
      r = rows[0];
      r.nb = 20;
      run(r);
      check(sawFull, 1'b1);
      slow <= 1'b1;
      r.a = 24'h0007f0;
      run(r);
      slow <= 1'b0;
      conclude();
   end
endmodule
